/* File: rtl/ecl_pkg.sv */
package ecl_pkg;

  // ****************************************
  // Serial bus timing
  // ****************************************
  localparam int CLK_HZ = 40_000_000;
  localparam int SCL_QUARTER_NS = 2500;
  localparam int SCL_QUARTER_CYC = (SCL_QUARTER_NS * (CLK_HZ / 1_000_000) + 999) / 1000;

  // ****************************************
  // ROM addressing
  // ****************************************
  localparam logic [6:0] ROM_ADDR7 = 7'h50;
  localparam logic [4:0] ROM_FIRST = 5'h00;
  localparam logic [4:0] ROM_LAST = 5'h1c;
  localparam logic [4:0] ROM_CMD = 5'h02;
  localparam logic [7:0] CFG_CMD_LO = 8'h04;
  localparam logic [7:0] CFG_CMD_HI = 8'h05;
  localparam logic [7:0] CMD_LO_MASK = 8'h67;
  localparam logic [7:0] CMD_HI_MASK = 8'h01;

  typedef enum {
    ST_DETECT,
    ST_START,
    ST_TX,
    ST_RX,
    ST_APPLY,
    ST_APPLY2,
    ST_STOP,
    ST_DONE
  } ecl_state_t;

  typedef struct packed {
    logic we;
    logic [7:0] addr;
    logic [7:0] data;
    logic [7:0] mask;
  } ecl_cfg_wr_t;

  typedef struct packed {
    logic hit;
    logic [7:0] addr;
    logic [7:0] mask;
  } ecl_map_t;

endpackage

/* File: rtl/ecl_loader.sv */
// Functional notes
// - ROM byte 02h updates selected bits of command register at 04h.
// - Bit7 to command bit8, bits6-5 and 2-0 direct, bits4-3 ignored.
// - ROM 04h-07h load subsystem IDs into 40h-43h, low byte first.
// - ROM byte 0Fh never written; system control byte 82h stays unchanged.
// - ROM 11h-14h load multifunction_pin_routing at 8Ch-8Fh, LSB first.
// - Start after reset only when clock line reads high via pull-up.
// - ROM addressed at seven-bit slave address 1010000b.
`timescale 1ns/1ps
`default_nettype none
module ecl_loader
  import ecl_pkg::*;
#(
  parameter int QTR_CYC = SCL_QUARTER_CYC
) (
  input wire logic clk_i,           // 40 MHz device clock
  input wire logic nrst_i,          // Host bus reset, active low
  input wire logic scl_i,           // Serial clock pin level
  output logic scl_o,               // Serial clock drive value
  output logic scl_oe_n_o,          // Low while pulling clock low
  input wire logic sda_i,           // Serial data pin level
  output logic sda_o,               // Serial data drive value
  output logic sda_oe_n_o,          // Low while pulling data low
  output var ecl_cfg_wr_t cfg_wr_o, // Config byte write with bit mask
  output logic busy_o,              // Load in progress
  output logic done_o,              // Load finished or skipped
  output logic err_o                // ROM did not acknowledge
);

  // ****************************************
  // Loading map
  // ****************************************
  function automatic ecl_map_t map_rom(input logic [4:0] off);
    ecl_map_t m;
    m = '{hit: 1'b0, addr: 8'h00, mask: 8'h00};
    case (off)
      5'h02: m = '{1'b1, CFG_CMD_LO, CMD_LO_MASK};
      5'h04: m = '{1'b1, 8'h40, 8'hff};
      5'h05: m = '{1'b1, 8'h41, 8'hff};
      5'h06: m = '{1'b1, 8'h42, 8'hff};
      5'h07: m = '{1'b1, 8'h43, 8'hff};
      5'h08: m = '{1'b1, 8'h44, 8'hfe};
      5'h09: m = '{1'b1, 8'h45, 8'hff};
      5'h0a: m = '{1'b1, 8'h46, 8'hff};
      5'h0b: m = '{1'b1, 8'h47, 8'hff};
      5'h0c: m = '{1'b1, 8'h80, 8'h7f};
      5'h0e: m = '{1'b1, 8'h81, 8'hc0};
      5'h10: m = '{1'b1, 8'h83, 8'hff};
      5'h11: m = '{1'b1, 8'h8c, 8'hff};
      5'h12: m = '{1'b1, 8'h8d, 8'hff};
      5'h13: m = '{1'b1, 8'h8e, 8'hff};
      5'h14: m = '{1'b1, 8'h8f, 8'hff};
      5'h15: m = '{1'b1, 8'h90, 8'hc0};
      5'h16: m = '{1'b1, 8'h91, 8'h80};
      // Bit 0 must stay 0, so it is never loaded
      5'h17: m = '{1'b1, 8'h92, 8'h7e};
      5'h18: m = '{1'b1, 8'h93, 8'h9f};
      5'h19: m = '{1'b1, 8'ha3, 8'h80};
      // 00h, 01h, 03h, 0Dh, 0Fh and 1Ah-1Ch carry nothing to load
      default: m = '{hit: 1'b0, addr: 8'h00, mask: 8'h00};
    endcase
    return m;
  endfunction

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [1:0] pin_in;
  logic [1:0] pin_f;
  assign pin_in = {sda_i, scl_i};

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_sync
      logic s1;
      logic s2;
      logic s3;
      always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
          s1 <= 1'b0;
          s2 <= 1'b0;
          s3 <= 1'b0;
          pin_f[gi] <= 1'b0;
        end else begin
          s1 <= pin_in[gi];
          s2 <= s1;
          s3 <= s2;
          if (s2 == s3) begin
            pin_f[gi] <= s3;
          end
        end
      end
    end
  endgenerate

  logic scl_f;
  logic sda_f;
  assign scl_f = pin_f[0];
  assign sda_f = pin_f[1];

  // ****************************************
  // Quarter bit timer
  // ****************************************
  logic [15:0] qcnt;
  logic tick;
  assign tick = (qcnt == 16'(QTR_CYC - 1));

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      qcnt <= 16'h0000;
    end else begin
      qcnt <= tick ? 16'h0000 : qcnt + 16'h0001;
    end
  end

  // ****************************************
  // Sequencer
  // ****************************************
  ecl_state_t state;
  logic [1:0] phase;
  logic [3:0] bitn;
  logic [7:0] shreg;
  logic [1:0] tx_step;
  logic [4:0] offset;
  logic ack_n;
  logic scl_low;
  logic sda_low;

  logic is_last;
  logic bit_end;
  ecl_map_t cur_map;
  assign is_last = (offset == ROM_LAST);
  assign bit_end = (bitn == 4'h8);
  assign cur_map = map_rom(offset);

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state <= ST_DETECT;
      phase <= 2'h0;
      bitn <= 4'h0;
      shreg <= 8'h00;
      tx_step <= 2'h0;
      offset <= ROM_FIRST;
      ack_n <= 1'b0;
      scl_low <= 1'b0;
      sda_low <= 1'b0;
      err_o <= 1'b0;
      cfg_wr_o <= '0;
    end else begin
      cfg_wr_o.we <= 1'b0;
      if (tick && (state == ST_START || state == ST_TX || state == ST_RX || state == ST_STOP)) begin
        phase <= phase + 2'h1;
      end
      case (state)
        ST_DETECT: begin
          // Five quarters cover the filter latency even with one-cycle quarters
          if (tick) begin
            if (bitn == 4'h4) begin
              state <= scl_f ? ST_START : ST_DONE;
            end else begin
              bitn <= bitn + 4'h1;
            end
          end
        end
        ST_START: begin
          if (tick) begin
            case (phase)
              2'h0: begin
                scl_low <= 1'b1;
                sda_low <= 1'b0;
              end
              2'h1: scl_low <= 1'b0;
              2'h2: sda_low <= 1'b1;
              default: begin
                scl_low <= 1'b1;
                state <= ST_TX;
                bitn <= 4'h0;
                shreg <= {ROM_ADDR7, (tx_step == 2'h2)};
              end
            endcase
          end
        end
        ST_TX: begin
          if (tick) begin
            case (phase)
              2'h0: sda_low <= bit_end ? 1'b0 : ~shreg[7];
              2'h1: scl_low <= 1'b0;
              2'h2: ack_n <= bit_end ? sda_f : ack_n;
              default: begin
                scl_low <= 1'b1;
                if (!bit_end) begin
                  shreg <= {shreg[6:0], 1'b0};
                  bitn <= bitn + 4'h1;
                end else if (ack_n) begin
                  err_o <= 1'b1;
                  state <= ST_STOP;
                end else if (tx_step == 2'h0) begin
                  tx_step <= 2'h1;
                  shreg <= {3'h0, ROM_FIRST};
                  bitn <= 4'h0;
                end else if (tx_step == 2'h1) begin
                  // Repeated start turns the bus round for reading
                  tx_step <= 2'h2;
                  state <= ST_START;
                end else begin
                  bitn <= 4'h0;
                  state <= ST_RX;
                end
              end
            endcase
          end
        end
        ST_RX: begin
          if (tick) begin
            case (phase)
              // Acknowledge every byte except the last one
              2'h0: sda_low <= bit_end ? ~is_last : 1'b0;
              2'h1: scl_low <= 1'b0;
              2'h2: shreg <= bit_end ? shreg : {shreg[6:0], sda_f};
              default: begin
                scl_low <= 1'b1;
                if (!bit_end) begin
                  bitn <= bitn + 4'h1;
                end else begin
                  state <= ST_APPLY;
                end
              end
            endcase
          end
        end
        ST_APPLY, ST_APPLY2: begin
          if (state == ST_APPLY) begin
            cfg_wr_o.we <= cur_map.hit;
            cfg_wr_o.addr <= cur_map.addr;
            cfg_wr_o.data <= shreg & cur_map.mask;
            cfg_wr_o.mask <= cur_map.mask;
          end else begin
            cfg_wr_o.we <= 1'b1;
            cfg_wr_o.addr <= CFG_CMD_HI;
            cfg_wr_o.data <= {7'h00, shreg[7]};
            cfg_wr_o.mask <= CMD_HI_MASK;
          end
          if (state == ST_APPLY && offset == ROM_CMD) begin
            state <= ST_APPLY2;
          end else if (is_last) begin
            state <= ST_STOP;
          end else begin
            offset <= offset + 5'h01;
            bitn <= 4'h0;
            state <= ST_RX;
          end
        end
        ST_STOP: begin
          if (tick) begin
            case (phase)
              2'h0: begin
                sda_low <= 1'b1;
                scl_low <= 1'b1;
              end
              2'h1: scl_low <= 1'b0;
              2'h2: sda_low <= 1'b0;
              default: state <= ST_DONE;
            endcase
          end
        end
        ST_DONE: begin
          scl_low <= 1'b0;
          sda_low <= 1'b0;
        end
        default: state <= ST_DONE;
      endcase
    end
  end

  // ****************************************
  // Pin drive and status
  // ****************************************
  // Open drain: only ever pull low, the pull-ups make the high level
  assign scl_o = 1'b0;
  assign sda_o = 1'b0;
  assign scl_oe_n_o = ~scl_low;
  assign sda_oe_n_o = ~sda_low;
  assign done_o = (state == ST_DONE);
  assign busy_o = ~done_o;

endmodule
`default_nettype wire

/* File: tb/ecl_loader_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
module ecl_loader_assertions
  import ecl_pkg::*;
#(
  parameter int QTR_CYC = SCL_QUARTER_CYC
) (
  input wire logic clk_i, // Clock
  input wire logic nrst_i, // Reset
  input wire logic scl_i, // Clock pin
  input wire logic scl_oe_n_o, // Clock pull
  input wire logic sda_oe_n_o, // Data pull
  input wire ecl_cfg_wr_t cfg_wr_o // Config write
);
  // ****************************************
  // Helpers and checks
  // ****************************************
  logic [7:0] last_addr;
  logic scl_seen_hi;
  wire logic we = cfg_wr_o.we;
  wire logic [7:0] ad = cfg_wr_o.addr;
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      last_addr <= 8'h00;
      scl_seen_hi <= 1'b0;
    end else begin
      if (we) last_addr <= ad;
      if (scl_i) scl_seen_hi <= 1'b1;
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  a_cmd_pair: assert property (we && ad == 8'h04 |=> we && ad == 8'h05 && cfg_wr_o.mask == 8'h01)
    else $error("command high byte not written after low byte");
  a_cmd_mask: assert property (we && ad == 8'h04 |-> cfg_wr_o.mask == 8'h67)
    else $error("command low byte mask wrong");
  a_ctl2_untouched: assert property (we |-> ad != 8'h82)
    else $error("system control byte 2 written");
  a_data_masked: assert property (we |-> (cfg_wr_o.data & ~cfg_wr_o.mask) == 8'h00)
    else $error("data outside mask");
  a_id_full: assert property (we && ad inside {[8'h40:8'h43]} |-> cfg_wr_o.mask == 8'hff)
    else $error("subsystem id byte partly written");
  a_multifunction_pin_routing_full: assert property (we && ad inside {[8'h8c:8'h8f]} |-> cfg_wr_o.mask == 8'hff)
    else $error("pin routing byte partly written");
  a_byte_order: assert property (we && ad inside {[8'h41:8'h43], [8'h8d:8'h8f]} |-> last_addr == ad - 8'h01)
    else $error("multi byte register out of order");
  a_no_pullup_idle: assert property (!scl_seen_hi |-> scl_oe_n_o && sda_oe_n_o)
    else $error("bus driven without clock pull-up");
  cover property (we && ad == 8'h8f);
  cover property (!scl_seen_hi ##1 !scl_seen_hi [*8]);
  cover property (we && ad == 8'h05);
endmodule
bind ecl_loader ecl_loader_assertions #(.QTR_CYC(QTR_CYC)) i_ecl_loader_assertions (
  .clk_i(clk_i),
  .nrst_i(nrst_i),
  .scl_i(scl_i),
  .scl_oe_n_o(scl_oe_n_o),
  .sda_oe_n_o(sda_oe_n_o),
  .cfg_wr_o(cfg_wr_o)
);
`default_nettype wire

/* File: tb/ecl_rom_model.sv */
`timescale 1ns/1ps
`default_nettype none
module ecl_rom_model (
  input wire logic scl_i, // Clock wire
  input wire logic sda_i, // Data wire
  input wire logic [6:0] addr_i, // Strapped address
  output logic sda_oe_n_o // Low pulls data
);
  logic [7:0] mem [0:31];
  logic [7:0] sh;
  logic [7:0] ptr = 8'h00;
  logic act = 1'b0;
  int bitn = 0;
  int phase = 0;
  initial sda_oe_n_o = 1'b1;
  always @(negedge sda_i) if (scl_i) begin
    act = 1'b1;
    bitn = -1;
    phase = 0;
  end
  always @(posedge sda_i) if (scl_i) act = 1'b0;
  always @(posedge scl_i) if (act && bitn < 8) sh = {sh[6:0], sda_i};
  // Master NACK on a read byte ends the slave's part, so STOP is seen
  always @(posedge scl_i) if (act && phase == 2 && bitn == 8 && sda_i) act = 1'b0;
  always @(negedge scl_i) if (act) begin
    bitn = bitn + 1;
    if (bitn == 9) begin
      bitn = 0;
      if (phase == 0) phase = sh[0] ? 2 : 1;
      else if (phase == 1) begin
        ptr = sh;
        phase = 3;
      end else ptr = ptr + 8'h01;
    end
    sda_oe_n_o = 1'b1;
    if (bitn == 8 && phase == 1) sda_oe_n_o = 1'b0;
    if (bitn == 8 && phase == 0) begin
      sda_oe_n_o = (sh[7:1] != addr_i);
      act = (sh[7:1] == addr_i);
    end
    if (phase == 2 && bitn < 8) sda_oe_n_o = mem[ptr[4:0]][7 - bitn];
  end
endmodule
`default_nettype wire

/* File: tb/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
  import ecl_pkg::*;
  logic clk_i, nrst_i, scl_pu, scl_o, scl_oe_n_o, sda_o, sda_oe_n_o, rom_oe_n, busy_o, done_o, err_o;
  logic [6:0] strap;
  ecl_cfg_wr_t cfg_wr_o;
  ecl_cfg_wr_t seen_q[$];
  int n_errors = 0, cmp_count = 0, seed = 32'h2a8a;
  // No pull-up means nothing lifts the clock wire
  wire logic scl_w = scl_pu & (scl_oe_n_o | scl_o);
  wire logic sda_w = (sda_oe_n_o | sda_o) & rom_oe_n;
  ecl_loader #(.QTR_CYC(4)) i_ecl_loader (.clk_i(clk_i), .nrst_i(nrst_i), .scl_i(scl_w), .scl_o(scl_o),
    .scl_oe_n_o(scl_oe_n_o), .sda_i(sda_w), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o), .cfg_wr_o(cfg_wr_o),
    .busy_o(busy_o), .done_o(done_o), .err_o(err_o));
  ecl_rom_model i_ecl_rom_model (.scl_i(scl_w), .sda_i(sda_w), .addr_i(strap), .sda_oe_n_o(rom_oe_n));
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) if (cfg_wr_o.we === 1'b1) seen_q.push_back(cfg_wr_o);
  function automatic ecl_map_t exp_map(input logic [7:0] o);
    case (o) inside
      [8'h04:8'h07], [8'h09:8'h0b]: return '{1'b1, o + 8'h3c, 8'hff};
      8'h08: return '{1'b1, 8'h44, 8'hfe};
      8'h0c: return '{1'b1, 8'h80, 8'h7f};
      8'h0e: return '{1'b1, 8'h81, 8'hc0};
      8'h10: return '{1'b1, 8'h83, 8'hff};
      [8'h11:8'h14]: return '{1'b1, o + 8'h7b, 8'hff};
      8'h15: return '{1'b1, 8'h90, 8'hc0};
      8'h16: return '{1'b1, 8'h91, 8'h80};
      8'h17: return '{1'b1, 8'h92, 8'h7e};
      8'h18: return '{1'b1, 8'h93, 8'h9f};
      8'h19: return '{1'b1, 8'ha3, 8'h80};
      default: return '{1'b0, 8'h00, 8'h00};
    endcase
  endfunction
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic print_verdict();
    $display("compares %0d errors %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic run(input logic pu, input logic [6:0] adr, input logic exp_err);
    ecl_cfg_wr_t exp_q[$];
    ecl_map_t m;
    logic [7:0] r;
    int k;
    @(posedge clk_i);
    #2 nrst_i = 1'b0;
    scl_pu = pu;
    strap = adr;
    repeat (12) @(posedge clk_i);
    #2 nrst_i = 1'b1;
    seen_q.delete();
    for (k = 0; k < 20000 && done_o !== 1'b1; k++) @(posedge clk_i);
    if (k == 20000) begin
      check("done_o", 32'(done_o), 32'h1);
      print_verdict();
    end
    @(posedge clk_i);
    #2 check("err_o", 32'(err_o), 32'(exp_err));
    check("busy_o pins", 32'({busy_o, scl_oe_n_o, sda_oe_n_o}), 32'h3);
    for (int o = 0; o < 29 && pu && !exp_err; o++) begin
      r = i_ecl_rom_model.mem[o];
      m = exp_map(8'(o));
      if (o == 2) begin
        exp_q.push_back('{1'b1, 8'h04, r & 8'h67, 8'h67});
        exp_q.push_back('{1'b1, 8'h05, {7'h00, r[7]}, 8'h01});
      end else if (m.hit) exp_q.push_back('{1'b1, m.addr, r & m.mask, m.mask});
    end
    check("write count", seen_q.size(), exp_q.size());
    foreach (exp_q[i]) if (i < seen_q.size()) check("cfg_wr_o", 32'(seen_q[i]), 32'(exp_q[i]));
  endtask
  initial begin
    nrst_i = 1'b0;
    scl_pu = 1'b1;
    strap = 7'h50;
    foreach (i_ecl_rom_model.mem[i]) i_ecl_rom_model.mem[i] = 8'hff;
    run(1'b1, 7'h50, 1'b0);
    foreach (i_ecl_rom_model.mem[i]) i_ecl_rom_model.mem[i] = 8'($random(seed));
    run(1'b1, 7'h50, 1'b0);
    run(1'b0, 7'h50, 1'b0);
    run(1'b1, 7'h51, 1'b1);
    print_verdict();
  end
endmodule
`default_nettype wire
